// File: lnbi_regs.vh
`ifndef LNBI_REGS_VH
`define LNBI_REGS_VH

// Fixed upper five bits of the seven-bit slave address.
`define LNBI_ADDR_BASE     5'h02
// Register select codes, carried in data bits 7:5.
`define LNBI_SEL_STATUS    3'h0
`define LNBI_SEL_TONE      3'h1
`define LNBI_SEL_COMMAND   3'h2
`define LNBI_SEL_CONTROL   3'h3
// Field positions.
`define LNBI_SEL_HI        7
`define LNBI_SEL_LO        5
`define LNBI_FIELD_HI      4
`define LNBI_FIELD_LO      0
// Reset value of the tone, command and control registers.
`define LNBI_REG_RST       8'h00
// Last bit index of a byte, and the acknowledge slot.
`define LNBI_BIT_LAST      3'h7
`define LNBI_CNT_ZERO      3'h0

`endif

// File: lnbi_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "lnbi_regs.vh"

// What this block does
// - START is SDA falling while SCL high.
// - STOP is SDA rising while SCL high.
// - SDA changes only while SCL is low.
// - Bytes are eight bits, MSB first, then acknowledge.
// - Any number of bytes per transfer accepted.
// - Slave holds SDA low through ninth pulse.
// - No acknowledge while supply-good is low.
// - SDA driven only open-drain: low or released.
// - Works at standard and fast-mode rates.
// - Address 00010 plus two pins, then direction.
// - Transaction: START, address, data byte, STOP.
// - Writes update registers two to four by code.
// - Three written registers and status select clear to zero at power-on; status flags stay live.
// - Overload bit reports output overcurrent shutdown.
// - Back-current bit reports reverse current shutdown.
// - Voltage-range bit reports input/output out of range.
// - Open-cable bit reports load current too low.
// - Overtemperature bit reports thermal shutdown.
// - Reads shift MSB first; master ack continues.
// - Supply-good low ignores bus, registers held zero.
// - Address pins supply the two lowest bits.
module lnbi_slave
(
    // Clock and reset
    input  wire       clock,
    input  wire       sys_rst,
    // Two-wire bus pins
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output reg        sda_oe,
    // Address strap pins and supply-good
    input  wire       addr_pin_bit1,
    input  wire       addr_pin_bit0,
    input  wire       power_ok,
    // Diagnostic inputs from the analog blocks
    input  wire       overtemp_flag,
    input  wire       open_cable_flag,
    input  wire       voltage_range_flag,
    input  wire       overload_flag,
    input  wire       back_current_flag,
    // System register contents
    output wire [7:0] fault_status,
    output wire [7:0] tone_setup,
    output wire [7:0] current_limit_command,
    output wire [7:0] output_control
);

////////////////////////////////////////////////////////////////////////////////

    // One state per slot of the frame. The acknowledge slots are states of
    // their own, so the pull-down is owned by one place only and is released
    // on the falling SCL edge that closes the ninth pulse, unless a read's first bit is zero.
    localparam ST_IDLE   = 3'h0;
    localparam ST_ADDR   = 3'h1;
    localparam ST_AACK   = 3'h2;
    localparam ST_WDATA  = 3'h3;
    localparam ST_WACK   = 3'h4;
    localparam ST_RDATA  = 3'h5;
    localparam ST_RACK   = 3'h6;

    function sel_writable;
        input [2:0] code;
        begin
            sel_writable = (code == `LNBI_SEL_TONE) ||
                           (code == `LNBI_SEL_COMMAND) ||
                           (code == `LNBI_SEL_CONTROL);
        end
    endfunction

    reg  [1:0] scl_sync_r;
    reg  [1:0] sda_sync_r;
    reg  [1:0] pok_sync_r;
    reg  [1:0] a1_sync_r;
    reg  [1:0] a0_sync_r;
    reg        scl_d_r;
    reg        sda_d_r;
    reg  [2:0] state_r;
    reg  [2:0] bit_cnt_r;
    reg  [7:0] shift_r;
    reg  [2:0] rd_sel_r;
    reg  [7:0] tone_r;
    reg  [7:0] cmd_r;
    reg  [7:0] ctrl_r;
    reg  [2:0] status_sel_r;
    reg        byte_full_r;
    reg  [4:0] flag_sync0_r;
    reg  [4:0] flag_sync1_r;

    wire       scl_s     = scl_sync_r[1];
    wire       sda_s     = sda_sync_r[1];
    wire       pok_s     = pok_sync_r[1];
    wire       scl_rise  = scl_s & ~scl_d_r;
    wire       scl_fall  = ~scl_s & scl_d_r;
    wire       start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire       stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
    wire [6:0] my_addr   = {`LNBI_ADDR_BASE, a1_sync_r[1],
                            a0_sync_r[1]};
    // Fields of the byte just shifted in.
    wire [2:0] rx_code   = shift_r[`LNBI_SEL_HI:`LNBI_SEL_LO];
    wire       rx_read   = shift_r[0];
    // A full byte, not merely a zero counter, ends the data phase: right
    // after START the counter is zero as well, and the first SCL fall
    // would otherwise be mistaken for the end of a byte.
    wire       byte_done = scl_fall & byte_full_r;
    wire [7:0] status_w;
    reg  [7:0] rd_byte;

    // The pin is never driven high; only the enable moves.
    assign sda_out = 1'b0;

    // The status byte is built from flops only: the select code and the
    // resampled diagnostic levels.
    assign status_w = {status_sel_r, flag_sync1_r};

    // Register outputs.
    assign fault_status          = status_w;
    assign tone_setup            = tone_r;
    assign current_limit_command = cmd_r;
    assign output_control        = ctrl_r;

    // Read-back source: the register that the last write selected. Codes
    // above 011 never reach the select register, so the default arm is
    // the status byte.
    always @*
    begin
        case (rd_sel_r)
            `LNBI_SEL_TONE:    rd_byte = tone_r;
            `LNBI_SEL_COMMAND: rd_byte = cmd_r;
            `LNBI_SEL_CONTROL: rd_byte = ctrl_r;
            default:           rd_byte = status_w;
        endcase
    end

////////////////////////////////////////////////////////////////////////////////
// Synchronisers. At 100 MHz a 400 kHz bus gives about 250 samples per bit,
// so two flops of delay plus one for edge finding is well inside margin.

    // Bus lines. Nothing reads the first stage of any synchroniser.
    always @(posedge clock)
    begin
        scl_sync_r <= {scl_sync_r[0], scl_in};
        sda_sync_r <= {sda_sync_r[0], sda_in};
    end

    // Supply-good and the address straps.
    always @(posedge clock)
    begin
        pok_sync_r <= {pok_sync_r[0], power_ok};
        a1_sync_r  <= {a1_sync_r[0], addr_pin_bit1};
        a0_sync_r  <= {a0_sync_r[0], addr_pin_bit0};
    end

    // The diagnostic levels come from analog comparators with no clock.
    // Resampling them costs two cycles of report latency, which a host
    // polling over the bus can never notice.
    always @(posedge clock)
    begin
        flag_sync0_r <= {overtemp_flag, open_cable_flag,
                         voltage_range_flag, overload_flag,
                         back_current_flag};
        flag_sync1_r <= flag_sync0_r;
    end

    // Edge finder, one stage after the sampler. Its reset value is the
    // idle level of both lines, so no false edge follows reset.
    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Bus engine. Data is sampled on SCL rising and SDA is changed only after
// SCL falls, so the slave never moves SDA while the clock is high.
// A write walks IDLE, ADDR, AACK, then WDATA and WACK for every byte until
// STOP. A read walks IDLE, ADDR, AACK, then RDATA and RACK for as long as
// the master acknowledges. Each SDA change lands about three system clocks
// after the SCL fall that allows it, which leaves most of the low half of
// even a fast-mode clock for setup at the master.
// Limitation: SCL phases shorter than about four system clocks are not
// resolved, so the system clock must run at least eight times the bit
// rate of the bus.

    always @(posedge clock)
    begin
        if (sys_rst || !pok_s)
        begin
            // Supply-good low holds the whole engine in reset, registers
            // included, so the power blocks stay off and nothing is
            // acknowledged.
            state_r      <= ST_IDLE;
            byte_full_r  <= 1'b0;
            bit_cnt_r    <= `LNBI_CNT_ZERO;
            shift_r      <= `LNBI_REG_RST;
            rd_sel_r     <= `LNBI_SEL_STATUS;
            status_sel_r <= `LNBI_SEL_STATUS;
            tone_r       <= `LNBI_REG_RST;
            cmd_r        <= `LNBI_REG_RST;
            ctrl_r       <= `LNBI_REG_RST;
            sda_oe       <= 1'b0;
        end
        else if (stop_det)
        begin
            // A STOP ends any frame, a cut one too, and drops the pull-down.
            state_r     <= ST_IDLE;
            sda_oe      <= 1'b0;
            byte_full_r <= 1'b0;
        end
        else if (start_det)
        begin
            // A repeated start is also taken here; the master is expected
            // to STOP first, but resyncing is the safe reaction.
            state_r   <= ST_ADDR;
            bit_cnt_r <= `LNBI_CNT_ZERO;
            sda_oe    <= 1'b0;
            byte_full_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_ADDR, ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shift_r     <= {shift_r[6:0], sda_s};
                        bit_cnt_r   <= bit_cnt_r + 3'h1;
                        byte_full_r <= (bit_cnt_r == `LNBI_BIT_LAST);
                    end
                    else if (byte_done)
                    begin
                        byte_full_r <= 1'b0;
                        if (state_r == ST_ADDR)
                        begin
                            if (shift_r[7:1] == my_addr)
                            begin
                                sda_oe  <= 1'b1;
                                state_r <= ST_AACK;
                                if (rx_read)
                                    rd_sel_r <= status_sel_r;
                            end
                            else
                                // Another slave is addressed: stay off
                                // the bus until the next START.
                                state_r <= ST_IDLE;
                        end
                        else
                        begin
                            sda_oe  <= 1'b1;
                            state_r <= ST_WACK;
                            case (rx_code)
                                `LNBI_SEL_TONE:    tone_r <= shift_r;
                                `LNBI_SEL_COMMAND: cmd_r  <= shift_r;
                                `LNBI_SEL_CONTROL: ctrl_r <= shift_r;
                                default:           ;
                            endcase
                            // Codes 100..111 are acknowledged but leave
                            // the read-back target where it was.
                            if (rx_code == `LNBI_SEL_STATUS ||
                                sel_writable(rx_code))
                                status_sel_r <= rx_code;
                        end
                    end
                end
                ST_AACK, ST_WACK:
                begin
                    // Release after the ninth pulse, or start the read.
                    if (scl_fall)
                    begin
                        bit_cnt_r <= `LNBI_CNT_ZERO;
                        if (state_r == ST_AACK && rx_read)
                        begin
                            // The first read bit goes out on the edge that
                            // ends the acknowledge, with most of SCL low left.
                            state_r <= ST_RDATA;
                            shift_r <= {rd_byte[6:0], 1'b0};
                            sda_oe  <= ~rd_byte[7];
                        end
                        else
                        begin
                            state_r <= ST_WDATA;
                            sda_oe  <= 1'b0;
                        end
                    end
                end
                ST_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_r == `LNBI_BIT_LAST)
                        begin
                            // Release for the master's acknowledge.
                            sda_oe  <= 1'b0;
                            state_r <= ST_RACK;
                        end
                        else
                        begin
                            sda_oe  <= ~shift_r[7];
                            shift_r <= {shift_r[6:0], 1'b0};
                        end
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                    end
                end
                ST_RACK:
                begin
                    // Master low on the ninth pulse asks for one more byte.
                    if (scl_rise)
                        state_r <= sda_s ? ST_IDLE : ST_RACK;
                    else if (scl_fall)
                    begin
                        state_r   <= ST_RDATA;
                        bit_cnt_r <= `LNBI_CNT_ZERO;
                        shift_r   <= {rd_byte[6:0], 1'b0};
                        sda_oe    <= ~rd_byte[7];
                    end
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

endmodule // lnbi_slave
`default_nettype wire

// File: lnbi_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module lnbi_monitor (
    // Clock and reset
    input wire logic       clock,
    input wire logic       sys_rst,
    // Bus side
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       power_ok,
    // Diagnostics and registers
    input wire logic       overtemp_flag,
    input wire logic       open_cable_flag,
    input wire logic       voltage_range_flag,
    input wire logic       overload_flag,
    input wire logic       back_current_flag,
    input wire logic [7:0] fault_status,
    input wire logic [7:0] tone_setup,
    input wire logic [7:0] current_limit_command,
    input wire logic [7:0] output_control
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////
    property p_open_drain; sda_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data pin driven high");
    property p_oe_scl_low; $changed(sda_oe) |-> !scl_in; endproperty
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("data moved while clock high");
    // Six cycles cover the two-flop sync of the supply-good input.
    property p_nopwr_ack; !power_ok [*6] |-> !sda_oe; endproperty
    a_nopwr_ack: assert property (p_nopwr_ack)
        else $error("acknowledge without supply");
    property p_nopwr_regs; !power_ok [*6] |->
        (tone_setup | current_limit_command | output_control) == 8'h00;
    endproperty
    a_nopwr_regs: assert property (p_nopwr_regs)
        else $error("registers kept without supply");
    property p_rst_clear; $fell(sys_rst) |-> fault_status[7:5] == 3'h0
        && (tone_setup | current_limit_command | output_control) == 8'h00;
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("registers not cleared");
    // The flags pass a two-flop resampler before they show.
    property p_flags; fault_status[4:0] == $past({overtemp_flag,
        open_cable_flag, voltage_range_flag, overload_flag,
        back_current_flag}, 2);
    endproperty
    a_flags: assert property (p_flags)
        else $error("status flags wrong");
    property p_code_ok; fault_status[7] == 1'b0; endproperty
    a_code_ok: assert property (p_code_ok)
        else $error("unused select code kept");
    property p_write_code;
        ($changed(tone_setup) |-> tone_setup[7:5] == 3'h1
            || tone_setup == 8'h00) and
        ($changed(current_limit_command) |-> current_limit_command[7:5]
            == 3'h2 || current_limit_command == 8'h00) and
        ($changed(output_control) |-> output_control[7:5] == 3'h3
            || output_control == 8'h00);
    endproperty
    a_write_code: assert property (p_write_code)
        else $error("register written by wrong code");
endmodule // lnbi_monitor
bind lnbi_slave lnbi_monitor u_mon (.clock(clock), .sys_rst(sys_rst),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .power_ok(power_ok), .overtemp_flag(overtemp_flag),
    .open_cable_flag(open_cable_flag),
    .voltage_range_flag(voltage_range_flag),
    .overload_flag(overload_flag), .back_current_flag(back_current_flag),
    .fault_status(fault_status), .tone_setup(tone_setup),
    .current_limit_command(current_limit_command),
    .output_control(output_control));
`default_nettype wire

// File: lnbi_host.sv
`timescale 1ns/1ps
`default_nettype none
module lnbi_host (
    // Clock line and data pull-down
    output var logic scl,
    output var logic sda_low,
    // Resolved data line
    input  wire logic sda
);
    // Steps of 20 ns give an 80 ns link clock; each level lasts four system
    // clocks, enough for the two-flop sampler and the edge finder.
    localparam time Q = 20ns;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    task automatic clk_bit(input logic b, output logic r);
        sda_low = !b;
        #Q;
        scl = 1'b1;
        #Q;
        r = sda;
        #Q;
        scl = 1'b0;
        #Q;
    endtask
    // Only ever called from idle or after stop_c, never as a restart.
    task automatic start_c;
        #Q;
        sda_low = 1'b1;
        #Q;
        scl = 1'b0;
        #Q;
    endtask
    task automatic stop_c;
        sda_low = 1'b1;
        #Q;
        scl = 1'b1;
        #Q;
        sda_low = 1'b0;
        #Q;
    endtask
    task automatic xfer(input logic [7:0] d, input logic mack,
                        output logic [7:0] q, output logic ack);
        for (int k = 7; k >= 0; k--)
            clk_bit(d[k], q[k]);
        clk_bit(!mack, ack);
    endtask
endmodule // lnbi_host
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        power_ok = 1'b1;
    logic [1:0]  pins = 2'h0;
    logic [4:0]  flags = 5'h00;
    logic        sda_oe, sda_out, scl, host_low, ack;
    logic [7:0]  fs, tone, cmd, ctl, q, r8;
    logic [7:0]  regs [1:3];
    logic [2:0]  sel;
    logic [31:0] seed = 32'h0000002E;
    integer      fails = 0;
    integer      tests_run = 0;
    integer      i;
    // Pull-up on the data line: low while either party pulls.
    wire         sda = !(host_low || sda_oe);
    always #5 clock = !clock;
    lnbi_slave DUT (.clock(clock), .sys_rst(sys_rst), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_pin_bit1(pins[1]), .addr_pin_bit0(pins[0]),
        .power_ok(power_ok), .overtemp_flag(flags[4]),
        .open_cable_flag(flags[3]), .voltage_range_flag(flags[2]),
        .overload_flag(flags[1]), .back_current_flag(flags[0]),
        .fault_status(fs), .tone_setup(tone),
        .current_limit_command(cmd), .output_control(ctl));
    lnbi_host host (.scl(scl), .sda_low(host_low), .sda(sda));
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd8();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_regs;
        chk8(tone, regs[1]);
        chk8(cmd, regs[2]);
        chk8(ctl, regs[3]);
        chk8(fs, {sel, flags});
    endtask
    task automatic clear_model;
        regs = '{8'h00, 8'h00, 8'h00};
        sel = 3'h0;
    endtask
    // A refused byte is not acknowledged, and the stop then aborts.
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input int n, input logic ok);
        host.start_c;
        host.xfer(a, 1'b0, q, ack);
        chk8({7'h00, ack}, {7'h00, !ok});
        for (int k = 0; k < n; k++)
        begin
            host.xfer(d, 1'b0, q, ack);
            chk8({7'h00, ack}, {7'h00, !ok});
            if (ok && d[7:5] <= 3'h3)
            begin
                sel = d[7:5];
                if (sel != 3'h0)
                    regs[sel] = d;
            end
            d = d + 8'h20;
        end
        host.stop_c;
        chk_regs;
    endtask
    task automatic rd(input logic [7:0] a);
        host.start_c;
        host.xfer(a, 1'b0, q, ack);
        chk8({7'h00, ack}, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            host.xfer(8'hFF, k == 0, q, ack);
            chk8(q, sel == 3'h0 ? {3'h0, flags} : regs[sel]);
        end
        host.stop_c;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #500us;
        fails++;
        test_done;
    end
    initial
    begin
        clear_model;
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        chk_regs;
        $display("test reset done");
        for (i = 0; i < 16; i++)
        begin
            r8 = rnd8();
            pins = r8[1:0];
            flags = r8[6:2];
            r8 = rnd8();
            wr({5'h02, pins, 1'b0}, {i[2:0], r8[4:0]}, 1 + i[3],
               1'b1);
            rd({5'h02, pins, 1'b1});
        end
        $display("test write and read done");
        wr({5'h03, pins, 1'b0}, 8'h3F, 1, 1'b0);
        $display("test wrong address done");
        power_ok = 1'b0;
        repeat (6) @(negedge clock);
        clear_model;
        chk_regs;
        wr({5'h02, pins, 1'b0}, 8'h7F, 1, 1'b0);
        power_ok = 1'b1;
        repeat (4) @(negedge clock);
        wr({5'h02, pins, 1'b0}, 8'h55, 2, 1'b1);
        $display("test supply loss done");
        sys_rst = 1'b1;
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        clear_model;
        repeat (4) @(negedge clock);
        chk_regs;
        $display("test second reset done");
        test_done;
    end
endmodule // testbench
`default_nettype wire
